// File: design/fpu_ctrl_defines.vh
`ifndef FPU_CTRL_DEFINES_VH
`define FPU_CTRL_DEFINES_VH
// Register byte offsets.
`define OFS_CONTROL        4'h0
`define OFS_STATUS         4'h4
`define OFS_DECODE         4'h8
// Control word field positions.
`define CW_MASK_LSB        0
`define CW_MASK_MSB        5
`define CW_PREC_LSB        8
`define CW_PREC_MSB        9
`define CW_ROUND_LSB       10
`define CW_ROUND_MSB       11
`define CW_WRITE_MASK      16'h0F3F
`define CW_RESET           16'h033F
// Status word field positions.
`define SW_STACK_FAULT     6
// Exception vector bit positions.
`define EXC_INVALID        0
`define EXC_DENORMAL       1
`define EXC_ZERO_DIV       2
`define EXC_OVERFLOW       3
`define EXC_UNDERFLOW      4
`define EXC_INEXACT        5
// Precision select codes and significand widths.
`define PREC_SINGLE        2'h0
`define PREC_RESERVED      2'h1
`define PREC_DOUBLE        2'h2
`define PREC_EXTENDED      2'h3
`define SIG_SINGLE         7'h18
`define SIG_DOUBLE         7'h35
`define SIG_EXTENDED       7'h40
// Rounding select codes.
`define RND_NEAREST        2'h0
`define RND_DOWN           2'h1
`define RND_UP             2'h2
`define RND_CHOP           2'h3
// Operand classes.
`define CLS_ZERO           3'h0
`define CLS_NORMAL         3'h1
`define CLS_DENORM         3'h2
`define CLS_INF            3'h3
`define CLS_QNAN           3'h4
`define CLS_SNAN           3'h5
`define CLS_UNSUP          3'h6
// Operation kinds.
`define OPK_PREC           2'h0
`define OPK_ROUND          2'h1
`define OPK_PLAIN          2'h2
// Destination formats.
`define DST_FLOAT          2'h0
`define DST_INT            2'h1
`define DST_BCD            2'h2
// Substitute result actions.
`define ACT_NONE           3'h0
`define ACT_QNAN           3'h1
`define ACT_INT_IND        3'h2
`define ACT_BCD_IND        3'h3
`define ACT_INF            3'h4
`define ACT_MAX_FINITE     3'h5
`define ACT_DENORM         3'h6
`define ACT_ZERO           3'h7
// Bus responses.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// File: design/exc_detect.v
`timescale 1ns/1ps
`include "fpu_ctrl_defines.vh"
// Combinational detection of the six exception conditions for one operation.
module exc_detect (
   input  wire [2:0] a_class,        // Class of the first operand.
   input  wire [2:0] b_class,        // Class of the second operand.
   input  wire       b_used,         // Second operand takes part.
   input  wire       is_div,         // Operation is a divide.
   input  wire [1:0] op_kind,        // Rounding behaviour of the operation.
   input  wire       indeterminate,  // Datapath saw an indeterminate form.
   input  wire       stack_over,     // Register stack overflow.
   input  wire       stack_under,    // Register stack underflow.
   input  wire       too_large,      // Result magnitude beyond the format.
   input  wire       too_small,      // Nonzero true result too small.
   input  wire       loss_accuracy,  // Denormalization lost accuracy.
   input  wire       not_exact,      // True result not representable.
   input  wire       uf_masked,      // Underflow mask bit.
   output wire [5:0] exc,            // Detected exceptions.
   output wire       stack_case      // Invalid came from the stack.
);

   wire b_snan;  // Second operand signaling NaN.
   wire b_unsup; // Second operand in unsupported format.
   wire a_fin;   // First operand finite and nonzero.

   assign b_snan  = b_used && (b_class == `CLS_SNAN);
   assign b_unsup = b_used && (b_class == `CLS_UNSUP);
   assign a_fin   = (a_class == `CLS_NORMAL) || (a_class == `CLS_DENORM);
   assign stack_case = stack_over || stack_under;

   assign exc[`EXC_INVALID] = (a_class == `CLS_SNAN) || b_snan || (a_class == `CLS_UNSUP) ||
                              b_unsup || indeterminate || stack_case;
   assign exc[`EXC_DENORMAL] = (a_class == `CLS_DENORM) ||
                               (b_used && (b_class == `CLS_DENORM));
   assign exc[`EXC_ZERO_DIV] = is_div && b_used && (b_class == `CLS_ZERO) && a_fin;
   assign exc[`EXC_OVERFLOW] = too_large;
   assign exc[`EXC_UNDERFLOW] = too_small && (!uf_masked || loss_accuracy);
   assign exc[`EXC_INEXACT] = not_exact && (op_kind != `OPK_PLAIN);

endmodule

// File: design/fpu_control_exception_policy.v
`timescale 1ns/1ps
`include "fpu_ctrl_defines.vh"
module fpu_control_exception_policy (
   input  wire        CLK,            // Core clock.
   input  wire        RESETN,         // Asynchronous reset, active low.
   // AXI4-Lite register port.
   input  wire [3:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output wire [1:0]  S_AXI_BRESP,
   output wire        S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [3:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0]  S_AXI_RRESP,
   output wire        S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   // Datapath request.
   input  wire        OP_VALID,       // One-cycle strobe per operation.
   input  wire [1:0]  OP_KIND,        // Rounding behaviour of the operation.
   input  wire        OP_IS_DIV,      // Operation is a divide.
   input  wire [1:0]  OP_DEST_FMT,    // Destination format.
   input  wire        OP_RES_SIGN,    // Sign of the true result.
   input  wire [2:0]  OP_A_CLASS,     // First operand class.
   input  wire [2:0]  OP_B_CLASS,     // Second operand class.
   input  wire        OP_B_USED,      // Second operand takes part.
   input  wire        OP_INDETERM,    // Indeterminate form seen.
   input  wire        OP_STACK_OVER,  // Stack overflow.
   input  wire        OP_STACK_UNDER, // Stack underflow.
   input  wire        OP_TOO_LARGE,   // Result too large.
   input  wire        OP_TOO_SMALL,   // Nonzero result too small.
   input  wire        OP_LOSS_ACC,    // Denormalization lost accuracy.
   input  wire        OP_DENORM_RES,  // Denormal result representable.
   input  wire        OP_NOT_EXACT,   // Result not exactly representable.
   // Settings to the datapath.
   output wire [6:0]  SIG_WIDTH,      // Significand width for this kind.
   output wire [1:0]  ROUND_MODE,     // Rounding mode for this kind.
   output wire        ROUND_APPLY,    // Operation rounds its result.
   // Policy answer, one cycle after OP_VALID.
   output wire        RES_VALID,      // Answer strobe.
   output wire [2:0]  RES_ACTION,     // Substitute result to deliver.
   output wire [5:0]  RES_EXC,        // Exceptions detected.
   output wire        FPU_ERROR       // Unmasked exception strobe.
);

   // ------------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------------

   function [6:0] sig_of;
      input [1:0] prec;
      begin
         case (prec)
            `PREC_SINGLE:   sig_of = `SIG_SINGLE;
            `PREC_DOUBLE:   sig_of = `SIG_DOUBLE;
            `PREC_EXTENDED: sig_of = `SIG_EXTENDED;
            // The reserved code falls back to the widest form, the safe choice.
            default:        sig_of = `SIG_EXTENDED;
         endcase
      end
   endfunction

   function [2:0] ovf_act;
      input [1:0] rnd;
      input       neg;
      begin
         case (rnd)
            `RND_NEAREST: ovf_act = `ACT_INF;
            `RND_DOWN:    ovf_act = neg ? `ACT_INF : `ACT_MAX_FINITE;
            `RND_UP:      ovf_act = neg ? `ACT_MAX_FINITE : `ACT_INF;
            default:      ovf_act = `ACT_MAX_FINITE;
         endcase
      end
   endfunction

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------

   reg rst_meta_reg; // First stage, read only by the second.
   reg rst_sync_reg; // Released reset used by the design.
   wire rst_n;       // Synchronous-release reset, active low.

   // Reset asserts at once and releases two edges later.
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // ------------------------------------------------------------------
   // Register bus slave
   // ------------------------------------------------------------------

   reg [15:0] cw_reg;     // Control word.
   reg [6:0]  sticky_reg; // Sticky exception flags and stack fault flag.
   reg        aw_reg;     // Write address held.
   reg [3:0]  awaddr_reg; // Held write address.
   reg        w_reg;      // Write data held.
   reg [31:0] wdata_reg;  // Held write data.
   reg [3:0]  wstrb_reg;  // Held write strobes.
   reg        bvalid_reg; // Write response pending.
   reg [1:0]  bresp_reg;  // Write response code.
   reg        rvalid_reg; // Read data pending.
   reg [31:0] rdata_reg;  // Read data.
   reg [1:0]  rresp_reg;  // Read response code.
   wire       do_write;   // Both halves of a write held.
   wire       clr_status; // Status clear strobe this cycle.
   wire [6:0] clr_bits;   // Bits that software clears.
   wire [15:0] cw_next;   // Control word after a write.
   wire [1:0] prec_select;     // Precision field.
   wire [1:0] rounding_select; // Rounding field.
   wire [5:0] mask_bits;       // Exception masks.

   assign mask_bits = cw_reg[`CW_MASK_MSB:`CW_MASK_LSB];
   assign prec_select = cw_reg[`CW_PREC_MSB:`CW_PREC_LSB];
   assign rounding_select = cw_reg[`CW_ROUND_MSB:`CW_ROUND_LSB];

   assign do_write   = aw_reg && w_reg && !bvalid_reg;
   assign clr_status = do_write && (awaddr_reg == `OFS_STATUS) && wstrb_reg[0];
   assign clr_bits   = clr_status ? wdata_reg[6:0] : 7'h00;
   // Reserved control bits always load as zero.
   assign cw_next = {wstrb_reg[1] ? wdata_reg[15:8] : cw_reg[15:8],
                     wstrb_reg[0] ? wdata_reg[7:0] : cw_reg[7:0]} & `CW_WRITE_MASK;

   assign S_AXI_AWREADY = !aw_reg;
   assign S_AXI_WREADY  = !w_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign S_AXI_RRESP   = rresp_reg;

   // Address and data are latched in either order; the write lands once both are held.
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_reg     <= 1'b0;
         awaddr_reg <= 4'h0;
         w_reg      <= 1'b0;
         wdata_reg  <= 32'h00000000;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
         cw_reg     <= `CW_RESET;
      end else begin
         if (S_AXI_AWVALID && !aw_reg) begin
            aw_reg     <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_reg) begin
            w_reg     <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
         if (do_write) begin
            aw_reg     <= 1'b0;
            w_reg      <= 1'b0;
            bvalid_reg <= 1'b1;
            // Unmapped and read-only offsets answer with a slave error.
            if (awaddr_reg == `OFS_CONTROL) begin
               cw_reg    <= cw_next;
               bresp_reg <= `RESP_OKAY;
            end else if (awaddr_reg == `OFS_STATUS) begin
               bresp_reg <= `RESP_OKAY;
            end else begin
               bresp_reg <= `RESP_SLVERR;
            end
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Reads are answered on the same edge that takes the address.
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= `RESP_OKAY;
         case (S_AXI_ARADDR)
            `OFS_CONTROL: rdata_reg <= {16'h0000, cw_reg};
            `OFS_STATUS:  rdata_reg <= {25'h0000000, sticky_reg};
            `OFS_DECODE:  rdata_reg <= {23'h000000, rounding_select, sig_of(prec_select)};
            default: begin
               rdata_reg <= 32'h00000000;
               rresp_reg <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Settings toward the datapath
   // ------------------------------------------------------------------

   assign SIG_WIDTH = (OP_KIND == `OPK_PREC) ? sig_of(prec_select) : `SIG_EXTENDED;
   assign ROUND_APPLY = (OP_KIND != `OPK_PLAIN);
   assign ROUND_MODE  = ROUND_APPLY ? rounding_select : `RND_NEAREST;

   // ------------------------------------------------------------------
   // Exception detection and policy
   // ------------------------------------------------------------------

   wire [5:0] exc;        // Detected exceptions this cycle.
   wire       stack_case; // Invalid due to the register stack.
   wire [5:0] unmasked;   // Detected and not masked.
   reg  [2:0] act_next;   // Substitute result chosen now.

   exc_detect u_detect (
      .a_class       (OP_A_CLASS),
      .b_class       (OP_B_CLASS),
      .b_used        (OP_B_USED),
      .is_div        (OP_IS_DIV),
      .op_kind       (OP_KIND),
      .indeterminate (OP_INDETERM),
      .stack_over    (OP_STACK_OVER),
      .stack_under   (OP_STACK_UNDER),
      .too_large     (OP_TOO_LARGE),
      .too_small     (OP_TOO_SMALL),
      .loss_accuracy (OP_LOSS_ACC),
      .not_exact     (OP_NOT_EXACT),
      .uf_masked     (mask_bits[`EXC_UNDERFLOW]),
      .exc           (exc),
      .stack_case    (stack_case)
   );

   assign unmasked = exc & ~mask_bits;

   // Priority is invalid, zero divide, overflow, underflow; the rest substitute nothing.
   always @* begin
      act_next = `ACT_NONE;
      if (unmasked != 6'h00) begin
         act_next = `ACT_NONE;
      end else if (exc[`EXC_INVALID]) begin
         case (OP_DEST_FMT)
            `DST_INT: act_next = `ACT_INT_IND;
            `DST_BCD: act_next = `ACT_BCD_IND;
            default:  act_next = `ACT_QNAN;
         endcase
      end else if (exc[`EXC_ZERO_DIV]) begin
         act_next = `ACT_INF;
      end else if (exc[`EXC_OVERFLOW]) begin
         act_next = ovf_act(rounding_select, OP_RES_SIGN);
      end else if (exc[`EXC_UNDERFLOW]) begin
         act_next = OP_DENORM_RES ? `ACT_DENORM : `ACT_ZERO;
      end
   end

   reg       res_valid_reg;  // Answer strobe.
   reg [2:0] res_action_reg; // Substitute result.
   reg [5:0] res_exc_reg;    // Detected exceptions.
   reg       error_reg;      // Unmasked exception strobe.

   // The answer is registered so the datapath sees it one edge after its strobe.
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         res_valid_reg  <= 1'b0;
         res_action_reg <= `ACT_NONE;
         res_exc_reg    <= 6'h00;
         error_reg      <= 1'b0;
      end else begin
         res_valid_reg <= OP_VALID;
         if (OP_VALID) begin
            res_action_reg <= act_next;
            res_exc_reg    <= exc;
         end
         error_reg <= OP_VALID && (unmasked != 6'h00);
      end
   end

   // A new event wins over a clear in the same cycle.
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sticky_reg <= 7'h00;
      end else begin
         sticky_reg[5:0] <= (sticky_reg[5:0] & ~clr_bits[5:0]) | (OP_VALID ? exc : 6'h00);
         sticky_reg[`SW_STACK_FAULT] <= (sticky_reg[`SW_STACK_FAULT] &
                                        ~clr_bits[`SW_STACK_FAULT]) |
                                        (OP_VALID && stack_case);
      end
   end

   assign RES_VALID  = res_valid_reg;
   assign RES_ACTION = res_action_reg;
   assign RES_EXC    = res_exc_reg;
   assign FPU_ERROR  = error_reg;

endmodule

// File: dv/fpu_policy_checker_assertions.sv
`timescale 1ns/1ps
`include "fpu_ctrl_defines.vh"
// Watches the policy port and the settings offered to the datapath.
module fpu_policy_checker (
   input wire       CLK,
   input wire       RESETN,
   input wire       OP_VALID,
   input wire [1:0] OP_KIND,
   input wire       OP_IS_DIV,
   input wire       OP_B_USED,
   input wire [2:0] OP_A_CLASS,
   input wire [2:0] OP_B_CLASS,
   input wire       OP_TOO_LARGE,
   input wire       OP_NOT_EXACT,
   input wire [6:0] SIG_WIDTH,
   input wire [1:0] ROUND_MODE,
   input wire       ROUND_APPLY,
   input wire       RES_VALID,
   input wire [5:0] RES_EXC,
   input wire       FPU_ERROR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // The answer is one strobe, one cycle after each request.
   sequence s_answer;
      ##1 RES_VALID;
   endsequence
   sequence s_quiet;
      ##1 !RES_VALID;
   endsequence
   property p_answer;
      OP_VALID |-> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("answer missing");
   property p_quiet;
      !OP_VALID |-> s_quiet;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_err;
      FPU_ERROR |-> RES_VALID;
   endproperty
   a_err: assert property (p_err) else $error("error outside answer");
   // Only the arithmetic kind may run at reduced precision.
   property p_ext;
      OP_KIND != `OPK_PREC |-> SIG_WIDTH == `SIG_EXTENDED;
   endproperty
   a_ext: assert property (p_ext) else $error("precision on other kind");
   property p_rnd;
      ROUND_APPLY == (OP_KIND != `OPK_PLAIN) && (ROUND_APPLY || ROUND_MODE == `RND_NEAREST);
   endproperty
   a_rnd: assert property (p_rnd) else $error("rounding on plain kind");
   property p_zdiv;
      OP_VALID && OP_IS_DIV && OP_B_USED && OP_B_CLASS == `CLS_ZERO
         && OP_A_CLASS == `CLS_NORMAL |=> RES_EXC[`EXC_ZERO_DIV];
   endproperty
   a_zdiv: assert property (p_zdiv) else $error("zero divide missed");
   property p_ovf;
      OP_VALID && OP_TOO_LARGE |=> RES_EXC[`EXC_OVERFLOW];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow missed");
   property p_inx;
      OP_VALID |=> RES_EXC[`EXC_INEXACT] == $past(OP_NOT_EXACT && OP_KIND != `OPK_PLAIN);
   endproperty
   a_inx: assert property (p_inx) else $error("inexact wrong");
   property p_den;
      OP_VALID && OP_A_CLASS == `CLS_DENORM |=> RES_EXC[`EXC_DENORMAL];
   endproperty
   a_den: assert property (p_den) else $error("denormal missed");
   property p_inv;
      OP_VALID && OP_A_CLASS inside {`CLS_SNAN, `CLS_UNSUP} |=> RES_EXC[`EXC_INVALID];
   endproperty
   a_inv: assert property (p_inv) else $error("invalid missed");
endmodule

bind fpu_control_exception_policy fpu_policy_checker u_chk (
   .CLK, .RESETN, .OP_VALID, .OP_KIND, .OP_IS_DIV, .OP_B_USED, .OP_A_CLASS,
   .OP_B_CLASS, .OP_TOO_LARGE, .OP_NOT_EXACT, .SIG_WIDTH, .ROUND_MODE,
   .ROUND_APPLY, .RES_VALID, .RES_EXC, .FPU_ERROR);

// File: dv/fpu_datapath_model.sv
`timescale 1ns/1ps
// Datapath stand-in. Fields go out packed, from the top: kind, divide,
// format, sign, class A, class B, B used, then eight condition flags.
module fpu_datapath_model (
   input  wire        CLK,
   input  wire [6:0]  SIG_WIDTH,
   input  wire [1:0]  ROUND_MODE,
   output reg         OP_VALID,
   output reg  [20:0] op_bus
);
   reg [6:0] sw; // Width offered while the request stood.
   reg [1:0] rm; // Rounding offered while the request stood.
   initial begin
      OP_VALID = 1'h0;
      op_bus   = 21'h0;
   end
   // Fields mean nothing once the strobe drops, so they are inverted
   // rather than held; a design that reads them late shows it.
   task op(input [20:0] v);
      @(posedge CLK);
      OP_VALID <= 1'h1;
      op_bus   <= v;
      @(posedge CLK);
      sw = SIG_WIDTH;
      rm = ROUND_MODE;
      OP_VALID <= 1'h0;
      op_bus   <= ~v;
      #1;
   endtask
endmodule

// File: dv/tb_fpu_control_exception_policy.sv
`timescale 1ns/1ps
`include "fpu_ctrl_defines.vh"
module tb_fpu_control_exception_policy;
   logic        CLK = 1'h0, RESETN = 1'h0;
   logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hF;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
   logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP, OP_KIND, OP_DEST_FMT, ROUND_MODE;
   wire  [31:0] S_AXI_RDATA;
   wire  [2:0]  OP_A_CLASS, OP_B_CLASS, RES_ACTION;
   wire         OP_VALID, OP_IS_DIV, OP_RES_SIGN, OP_B_USED, OP_INDETERM, OP_STACK_OVER;
   wire         OP_STACK_UNDER, OP_TOO_LARGE, OP_TOO_SMALL, OP_LOSS_ACC, OP_DENORM_RES;
   wire         OP_NOT_EXACT, ROUND_APPLY, RES_VALID, FPU_ERROR;
   wire  [6:0]  SIG_WIDTH;
   wire  [5:0]  RES_EXC;
   wire  [20:0] op_bus;
   integer      num_errors = 0, samples_checked = 0, cyc = 0, i;
   assign {OP_KIND, OP_IS_DIV, OP_DEST_FMT, OP_RES_SIGN, OP_A_CLASS, OP_B_CLASS, OP_B_USED,
           OP_INDETERM, OP_STACK_OVER, OP_STACK_UNDER, OP_TOO_LARGE, OP_TOO_SMALL,
           OP_LOSS_ACC, OP_DENORM_RES, OP_NOT_EXACT} = op_bus;
   always #10 CLK = ~CLK;
   fpu_control_exception_policy dut (
      .CLK, .RESETN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
      .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .OP_VALID, .OP_KIND, .OP_IS_DIV,
      .OP_DEST_FMT, .OP_RES_SIGN, .OP_A_CLASS, .OP_B_CLASS, .OP_B_USED, .OP_INDETERM,
      .OP_STACK_OVER, .OP_STACK_UNDER, .OP_TOO_LARGE, .OP_TOO_SMALL, .OP_LOSS_ACC,
      .OP_DENORM_RES, .OP_NOT_EXACT, .SIG_WIDTH, .ROUND_MODE, .ROUND_APPLY,
      .RES_VALID, .RES_ACTION, .RES_EXC, .FPU_ERROR);
   fpu_datapath_model dp (.CLK, .SIG_WIDTH, .ROUND_MODE, .OP_VALID, .op_bus);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input [31:0] got, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Address and data go out together; each drops when its own ready is seen.
   task wrc(input [3:0] ad, input [31:0] d, input [1:0] er);
      @(posedge CLK);
      S_AXI_AWADDR  <= ad;
      S_AXI_WDATA   <= d;
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID  <= 1'h1;
      S_AXI_BREADY  <= 1'h1;
      do begin
         @(posedge CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      end while (S_AXI_BVALID !== 1'h1);
      S_AXI_BREADY <= 1'h0;
      chk(S_AXI_BRESP, er);
   endtask
   task rdc(input [3:0] ad, input [31:0] ed, input [1:0] er);
      @(posedge CLK);
      S_AXI_ARADDR  <= ad;
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY  <= 1'h1;
      do begin
         @(posedge CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      end while (S_AXI_RVALID !== 1'h1);
      S_AXI_RREADY <= 1'h0;
      chk(S_AXI_RDATA, ed);
      chk(S_AXI_RRESP, er);
   endtask
   // One operation with B in use and a positive result.
   task run(input [1:0] k, input dv, input [1:0] f, input [2:0] a, input [2:0] b,
            input [7:0] fl, input [2:0] ea, input [5:0] ee, input er);
      dp.op({k, dv, f, 1'h0, a, b, 1'h1, fl});
      chk(RES_VALID, 1'h1);
      chk(RES_ACTION, ea);
      chk(RES_EXC, ee);
      chk(FPU_ERROR, er);
   endtask
   function [6:0] wexp(input [1:0] p);
      wexp = (p == `PREC_SINGLE) ? `SIG_SINGLE : (p == `PREC_DOUBLE) ? `SIG_DOUBLE : `SIG_EXTENDED;
   endfunction
   task final_report;
      $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // A hung handshake ends the run as a mismatch.
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors = num_errors + 1;
         final_report;
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge CLK);
      RESETN <= 1'h1;
      repeat (3) @(posedge CLK);
      rdc(`OFS_CONTROL, 32'h0000033F, `RESP_OKAY);
      rdc(`OFS_STATUS, 32'h0, `RESP_OKAY);
      rdc(`OFS_DECODE, 32'h00000040, `RESP_OKAY);
      rdc(4'hC, 32'h0, `RESP_SLVERR);
      wrc(`OFS_DECODE, 32'hFFFFFFFF, `RESP_SLVERR);
      rdc(`OFS_DECODE, 32'h00000040, `RESP_OKAY);
      $display("test reset_map done");
      // Every precision and rounding code; overflow follows the rounding mode.
      for (i = 0; i < 16; i = i + 1) begin
         wrc(`OFS_CONTROL, {20'hFFFFF, i[3:0], 8'hFF}, `RESP_OKAY);
         rdc(`OFS_CONTROL, {20'h0, i[3:0], 8'h3F}, `RESP_OKAY);
         rdc(`OFS_DECODE, {23'h0, i[3:2], wexp(i[1:0])}, `RESP_OKAY);
         run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h10,
             i[2] ? `ACT_MAX_FINITE : `ACT_INF, 6'h08, 1'h0);
         chk(dp.sw, wexp(i[1:0]));
         chk(dp.rm, i[3:2]);
      end
      wrc(`OFS_CONTROL, 32'h0000043F, `RESP_OKAY);
      run(`OPK_ROUND, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h01,
          `ACT_NONE, 6'h20, 1'h0);
      chk(dp.sw, `SIG_EXTENDED);
      chk(dp.rm, `RND_DOWN);
      run(`OPK_PLAIN, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h01,
          `ACT_NONE, 6'h00, 1'h0);
      chk(dp.rm, `RND_NEAREST);
      // A negative overflow rounding down goes to infinity; an idle B is ignored.
      dp.op({`OPK_PREC, 1'h0, `DST_FLOAT, 1'h1, `CLS_NORMAL, `CLS_NORMAL, 1'h1, 8'h10});
      chk(RES_ACTION, `ACT_INF);
      chk(RES_EXC, 6'h08);
      dp.op({`OPK_PLAIN, 1'h0, `DST_FLOAT, 1'h0, `CLS_NORMAL, `CLS_SNAN, 1'h0, 8'h00});
      chk(RES_ACTION, `ACT_NONE);
      chk(RES_EXC, 6'h00);
      $display("test modes done");
      wrc(`OFS_CONTROL, 32'h0000033F, `RESP_OKAY);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_SNAN, `CLS_NORMAL, 8'h00, `ACT_QNAN, 6'h01, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_INT, `CLS_UNSUP, `CLS_NORMAL, 8'h00, `ACT_INT_IND, 6'h01, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_BCD, `CLS_NORMAL, `CLS_NORMAL, 8'h80, `ACT_BCD_IND, 6'h01, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h20, `ACT_QNAN, 6'h01, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_DENORM, `CLS_NORMAL, 8'h00, `ACT_NONE, 6'h02, 1'h0);
      run(`OPK_PREC, 1'h1, `DST_FLOAT, `CLS_NORMAL, `CLS_ZERO, 8'h00, `ACT_INF, 6'h04, 1'h0);
      run(`OPK_PREC, 1'h1, `DST_FLOAT, `CLS_ZERO, `CLS_ZERO, 8'h80, `ACT_QNAN, 6'h01, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h0E, `ACT_DENORM, 6'h10, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h0C, `ACT_ZERO, 6'h10, 1'h0);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h08, `ACT_NONE, 6'h00, 1'h0);
      $display("test masked done");
      wrc(`OFS_CONTROL, 32'h0000032F, `RESP_OKAY);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h08, `ACT_NONE, 6'h10, 1'h1);
      wrc(`OFS_CONTROL, 32'h0000033B, `RESP_OKAY);
      run(`OPK_PREC, 1'h1, `DST_FLOAT, `CLS_NORMAL, `CLS_ZERO, 8'h00, `ACT_NONE, 6'h04, 1'h1);
      run(`OPK_PREC, 1'h0, `DST_FLOAT, `CLS_NORMAL, `CLS_NORMAL, 8'h10, `ACT_INF, 6'h08, 1'h0);
      rdc(`OFS_STATUS, 32'h0000007F, `RESP_OKAY);
      wrc(`OFS_STATUS, 32'h0000007F, `RESP_OKAY);
      rdc(`OFS_STATUS, 32'h0, `RESP_OKAY);
      $display("test unmasked_status done");
      final_report;
   end
endmodule
